// [hw/hub_port_power_config.sv]
// Operation
// - select low: shared pins are strap inputs
// - select low: report fixed default identity
// - select high: settings come from memory
// - overcurrent switches that port's power off
// - ganged: all enables together, any overcurrent
// - sample upstream, derive 25 MHz bit clock
// - detect port speed, pick slew automatically
// - power strap high: self powered, low: bus powered
// - memory mode: drive clock, else release
// - gang strap selects ganged or per-port
// - memory mode: bidirectional data, idle released
// - four ports, own enable and overcurrent
// - memory pins tri-stated outside own access
// - power enables active low open drain
// - overcurrent inputs active low, one each
// - reset initializes all logic
// - suspend indicator high while suspended
`timescale 1ns/1ps
`default_nettype none
`include "hub_port_power_config_defs.svh"

module hub_port_power_config #(
    parameter int PORTS       = 4,
    parameter int BIT_CLK_DIV = `HPC_BIT_CLK_DIV,
    parameter int SCL_HALF    = `HPC_SCL_HALF_CYC
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           config_memory_select_i,
    input  wire logic                           mem_clk_pin_i,
    output logic                                mem_clk_pin_o,
    output logic                                mem_clk_pin_oe_o,
    input  wire logic                           mem_data_pin_i,
    output logic                                mem_data_pin_o,
    output logic                                mem_data_pin_oe_o,
    input  wire logic [PORTS-1:0]               port_overcurrent_n_i,
    input  wire logic [PORTS-1:0]               port_power_request_i,
    output logic      [PORTS-1:0]               port_power_enable_n_o,
    output logic      [PORTS-1:0]               port_power_enable_n_oe_o,
    output logic      [PORTS-1:0]               port_overcurrent_o,
    input  wire logic [PORTS-1:0]               port_dp_i,
    input  wire logic [PORTS-1:0]               port_dm_i,
    output logic      [PORTS-1:0]               port_slow_slew_o,
    input  wire logic                           up_rx_i,
    output logic                                up_rx_bit_o,
    output logic                                bit_clk_o,
    input  wire logic                           suspend_req_i,
    output logic                                suspend_indicator_o,
    output hub_port_power_config_pkg::power_cfg_t power_cfg_o,
    output hub_port_power_config_pkg::ident_t     ident_o,
    output logic                                enum_enable_o
);
    import hub_port_power_config_pkg::*;

    localparam int SW = 4 + 3 * PORTS;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] raw;
    logic [SW-1:0] s1_r, s2_r, s3_r, st_r;
    logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;

    assign raw = {config_memory_select_i, mem_clk_pin_i, mem_data_pin_i, up_rx_i,
                  port_overcurrent_n_i, port_dp_i, port_dm_i};

    // overcurrent pins idle high: a low reset value would flag a false overcurrent
    localparam logic [SW-1:0] SYNC_IDLE = {4'h0, {PORTS{1'b1}}, {(2 * PORTS){1'b0}}};

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_comb begin
                s1_nxt[gi] = raw[gi];
                s2_nxt[gi] = s1_r[gi];
                s3_nxt[gi] = s2_r[gi];
                st_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : st_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_r <= SYNC_IDLE;
            s2_r <= SYNC_IDLE;
            s3_r <= SYNC_IDLE;
            st_r <= SYNC_IDLE;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            st_r <= st_nxt;
        end
    end

    logic             sel_s, clk_pin_s, data_pin_s, up_rx_s;
    logic [PORTS-1:0] oc_n_s, dp_s, dm_s;
    assign {sel_s, clk_pin_s, data_pin_s, up_rx_s, oc_n_s, dp_s, dm_s} = st_r;

    // ----------------------------------------------------------------
    // configuration source
    // ----------------------------------------------------------------
    cfg_state_t                      state_r, state_nxt;
    logic [15:0]                     cnt_r, cnt_nxt;
    logic [5:0]                      bit_r, bit_nxt;
    logic                            scl_r, scl_nxt;
    logic [`HPC_CMD_BITS-1:0]        cmd_r, cmd_nxt;
    logic [`HPC_DATA_BITS-1:0]       data_r, data_nxt;
    power_cfg_t                      cfg_r, cfg_nxt;
    ident_t                          id_r, id_nxt;
    logic                            ready_r, ready_nxt;
    logic                            tick;

    assign tick = (cnt_r == 16'(SCL_HALF - 1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 16'h0001;
        bit_nxt   = bit_r;
        scl_nxt   = scl_r;
        cmd_nxt   = cmd_r;
        data_nxt  = data_r;
        cfg_nxt   = cfg_r;
        id_nxt    = id_r;
        ready_nxt = ready_r;
        case (state_r)
            ST_SETTLE: begin
                // straps are caught once, after the synchronisers have filled
                if (cnt_r == 16'(`HPC_SETTLE_CYC)) begin
                    cnt_nxt = 16'h0000;
                    if (sel_s) begin
                        state_nxt = ST_CMD;
                        cmd_nxt   = `HPC_CMD_READ;
                        bit_nxt   = 6'h00;
                    end else begin
                        state_nxt = ST_DONE;
                        cfg_nxt.self_powered = clk_pin_s;
                        cfg_nxt.ganged       = data_pin_s;
                        id_nxt.vid = `HPC_DEFAULT_VID;
                        id_nxt.pid = `HPC_DEFAULT_PID;
                        ready_nxt  = 1'b1;
                    end
                end
            end
            ST_CMD: begin
                if (tick) begin
                    cnt_nxt = 16'h0000;
                    scl_nxt = ~scl_r;
                    if (scl_r) begin
                        cmd_nxt = {cmd_r[`HPC_CMD_BITS-2:0], 1'b0};
                        bit_nxt = bit_r + 6'h01;
                        if (bit_r == 6'(`HPC_CMD_BITS - 1)) begin
                            state_nxt = ST_READ;
                            bit_nxt   = 6'h00;
                        end
                    end
                end
            end
            ST_READ: begin
                if (tick) begin
                    cnt_nxt = 16'h0000;
                    scl_nxt = ~scl_r;
                    if (!scl_r) begin
                        data_nxt = {data_r[`HPC_DATA_BITS-2:0], data_pin_s};
                        bit_nxt  = bit_r + 6'h01;
                        if (bit_r == 6'(`HPC_DATA_BITS - 1)) begin
                            state_nxt = ST_DONE;
                            scl_nxt   = 1'b0;
                            ready_nxt = 1'b1;
                            id_nxt.vid = data_nxt[`HPC_VID_MSB:`HPC_VID_LSB];
                            id_nxt.pid = data_nxt[`HPC_PID_MSB:`HPC_PID_LSB];
                            cfg_nxt.self_powered = data_nxt[`HPC_CFG_PWR_BIT];
                            cfg_nxt.ganged       = data_nxt[`HPC_CFG_GANG_BIT];
                        end
                    end
                end
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_SETTLE;
            cnt_r   <= 16'h0000;
            bit_r   <= 6'h00;
            scl_r   <= 1'b0;
            cmd_r   <= '0;
            data_r  <= '0;
            cfg_r   <= '0;
            id_r    <= '0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            bit_r   <= bit_nxt;
            scl_r   <= scl_nxt;
            cmd_r   <= cmd_nxt;
            data_r  <= data_nxt;
            cfg_r   <= cfg_nxt;
            id_r    <= id_nxt;
            ready_r <= ready_nxt;
        end
    end

    // pins released outside our own access so another master may share the memory
    assign mem_clk_pin_o     = scl_r;
    assign mem_clk_pin_oe_o  = (state_r == ST_CMD) || (state_r == ST_READ);
    assign mem_data_pin_o    = cmd_r[`HPC_CMD_BITS-1];
    assign mem_data_pin_oe_o = (state_r == ST_CMD);
    assign power_cfg_o       = cfg_r;
    assign ident_o           = id_r;
    assign enum_enable_o     = ready_r;

    // ----------------------------------------------------------------
    // port power and overcurrent
    // ----------------------------------------------------------------
    logic [PORTS-1:0] oc_r, oc_nxt, en_r, en_nxt;

    always_comb begin
        // set wins over the clear by a dropped request
        oc_nxt = (oc_r & port_power_request_i) | ~oc_n_s;
        en_nxt = '0;
        if (ready_r) begin
            if (cfg_r.ganged) begin
                en_nxt = {PORTS{(|port_power_request_i) & ~(|oc_nxt)}};
            end else begin
                en_nxt = port_power_request_i & ~oc_nxt;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            oc_r <= '0;
            en_r <= '0;
        end else begin
            oc_r <= oc_nxt;
            en_r <= en_nxt;
        end
    end

    // open drain: pulling low switches the port on
    assign port_power_enable_n_o    = '0;
    assign port_power_enable_n_oe_o = en_r;
    assign port_overcurrent_o       = oc_r;

    // ----------------------------------------------------------------
    // bit clock, upstream sampling, speed, suspend
    // ----------------------------------------------------------------
    logic [7:0]       div_r, div_nxt;
    logic             bclk_r, bclk_nxt, rxb_r, rxb_nxt, susp_r, susp_nxt;
    logic [PORTS-1:0] low_r, low_nxt;

    always_comb begin
        div_nxt  = (div_r == 8'(BIT_CLK_DIV / 2 - 1)) ? 8'h00 : div_r + 8'h01;
        bclk_nxt = (div_r == 8'(BIT_CLK_DIV / 2 - 1)) ? ~bclk_r : bclk_r;
        rxb_nxt  = (div_r == 8'h00 && !bclk_r) ? up_rx_s : rxb_r;
        // idle J level tells speed; single-ended zero keeps the last answer
        low_nxt  = (dm_s & ~dp_s) | (low_r & ~(dp_s ^ dm_s));
        susp_nxt = suspend_req_i;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_r  <= 8'h00;
            bclk_r <= 1'b0;
            rxb_r  <= 1'b0;
            low_r  <= '0;
            susp_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            bclk_r <= bclk_nxt;
            rxb_r  <= rxb_nxt;
            low_r  <= low_nxt;
            susp_r <= susp_nxt;
        end
    end

    assign bit_clk_o           = bclk_r;
    assign up_rx_bit_o         = rxb_r;
    assign port_slow_slew_o    = low_r;
    assign suspend_indicator_o = susp_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_strap_path;
        state_r == ST_SETTLE && cnt_r == 16'(`HPC_SETTLE_CYC) && !sel_s;
    endsequence
    sequence s_mem_path;
        state_r == ST_SETTLE && cnt_r == 16'(`HPC_SETTLE_CYC) && sel_s;
    endsequence

    a_strap_identity: assert property (s_strap_path |=> ready_r && id_r.vid == `HPC_DEFAULT_VID
        && cfg_r.ganged == $past(data_pin_s)) else $error("strap identity wrong");
    a_strap_released: assert property (s_strap_path |=> !mem_clk_pin_oe_o && !mem_data_pin_oe_o)
        else $error("memory pins driven in strap mode");
    a_mem_starts: assert property (s_mem_path |=> mem_clk_pin_oe_o && mem_data_pin_oe_o
        && !enum_enable_o) else $error("memory read did not start");
    a_mem_no_enum: assert property ((state_r == ST_CMD || state_r == ST_READ) |-> !enum_enable_o)
        else $error("enumeration before configuration");
    a_done_release: assert property (state_r == ST_DONE |-> !mem_clk_pin_oe_o
        && !mem_data_pin_oe_o) else $error("memory pins not released");
    a_read_input: assert property (state_r == ST_READ |-> !mem_data_pin_oe_o && mem_clk_pin_oe_o)
        else $error("data pin driven while reading");
    a_oc_off: assert property ((!oc_n_s[0] && !cfg_r.ganged) |=> !port_power_enable_n_oe_o[0])
        else $error("port powered during overcurrent");
    a_gang_together: assert property ((ready_r && cfg_r.ganged) |=>
        (port_power_enable_n_oe_o == '0 || port_power_enable_n_oe_o == '1))
        else $error("ganged enables split");
    a_gang_any_oc: assert property ((cfg_r.ganged && !(&oc_n_s)) |=> port_power_enable_n_oe_o == '0)
        else $error("ganged ports not cut on overcurrent");
    a_bit_clk_rate: assert property ($changed(bit_clk_o) |=> $stable(bit_clk_o) ##1 $changed(bit_clk_o))
        else $error("bit clock rate wrong");
    a_suspend_level: assert property (suspend_req_i |=> suspend_indicator_o)
        else $error("suspend indicator low while suspended");

endmodule

`default_nettype wire

// [inc/hub_port_power_config_defs.svh]
`ifndef HUB_PORT_POWER_CONFIG_DEFS_SVH
`define HUB_PORT_POWER_CONFIG_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define HPC_CLK_PERIOD_NS      10
`define HPC_SCL_HALF_NS        1000
`define HPC_SCL_HALF_CYC       ((`HPC_SCL_HALF_NS + `HPC_CLK_PERIOD_NS - 1) / `HPC_CLK_PERIOD_NS)
`define HPC_SETTLE_CYC         8
`define HPC_BIT_CLK_DIV        4

// ----------------------------------------------------------------
// configuration memory access
// ----------------------------------------------------------------
`define HPC_CMD_BITS           9
`define HPC_CMD_READ           9'h180
`define HPC_DATA_BITS          48
`define HPC_VID_MSB            47
`define HPC_VID_LSB            32
`define HPC_PID_MSB            31
`define HPC_PID_LSB            16
`define HPC_CFG_GANG_BIT       1
`define HPC_CFG_PWR_BIT        0

// ----------------------------------------------------------------
// fixed identity, values are arbitrary
// ----------------------------------------------------------------
`define HPC_DEFAULT_VID        16'h1234
`define HPC_DEFAULT_PID        16'h5678

`endif

// [inc/hub_port_power_config_pkg.sv]
package hub_port_power_config_pkg;

    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_CMD,
        ST_READ,
        ST_DONE
    } cfg_state_t;

    typedef struct packed {
        logic self_powered;
        logic ganged;
    } power_cfg_t;

    typedef struct packed {
        logic [15:0] vid;
        logic [15:0] pid;
    } ident_t;

endpackage

// [test/hub_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// serial configuration memory behind the shared pins
// ----------------------------------------------------------------
module hub_mem_model (
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic [47:0] content_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic [8:0]       cmd_o
);
    int   rises;
    logic oe_r;

    // let go of the data line right after the last data rise, as a released memory would
    assign sda_oe_o = oe_r && (rises < 57);

    // command bits are taken on the clock rise, nine of them
    always @(posedge rst_i or posedge scl_i) begin
        if (rst_i) begin
            rises <= 0;
        end else begin
            rises <= rises + 1;
            if (rises < 9) begin
                cmd_o <= {cmd_o[7:0], sda_i};
            end
        end
    end

    // answer changes on the fall so it is stable around the sampling rise
    always @(posedge rst_i or negedge scl_i) begin
        if (rst_i) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= (rises >= 9) && (rises < 57);
            if (rises >= 9 && rises < 57) begin
                sda_o <= content_i[56 - rises];
            end
        end
    end
endmodule

`default_nettype wire

// [test/hub_port_power_config_test.sv]
`timescale 1ns/1ps
`default_nettype none

module hub_port_power_config_test;
    import hub_port_power_config_pkg::*;

    // half period must outlast the input sync and its agree stage, or reads slip a bit
    localparam int SCLH = 6;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        mode = 1'b0;
    logic        strap_pwr = 1'b0;
    logic        strap_gang = 1'b0;
    logic [3:0]  oc_n = 4'hf;
    logic [3:0]  req = 4'h0;
    logic [3:0]  dp = 4'h0;
    logic [3:0]  dm = 4'h0;
    logic        up_rx = 1'b0;
    logic        susp = 1'b0;
    logic [47:0] content = 48'h0;
    logic        clk_o, clk_oe, dat_o, dat_oe, m_d, m_oe, bit_clk, up_bit, susp_o, enum_en;
    logic [3:0]  pen_n, pen_oe, oc_flag, slew;
    logic [8:0]  cmd;
    power_cfg_t  cfg;
    ident_t      ident;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // in memory mode both shared pins carry a pull-down when nobody drives them; in strap mode they read the strap
    wire         clk_w = clk_oe ? clk_o : (mode ? 1'b0 : strap_pwr);
    wire         dat_w = dat_oe ? dat_o : (m_oe ? m_d : (mode ? 1'b0 : strap_gang));

    hub_port_power_config #(.SCL_HALF(SCLH)) dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .config_memory_select_i(mode),
        .mem_clk_pin_i(clk_w), .mem_clk_pin_o(clk_o), .mem_clk_pin_oe_o(clk_oe),
        .mem_data_pin_i(dat_w), .mem_data_pin_o(dat_o), .mem_data_pin_oe_o(dat_oe),
        .port_overcurrent_n_i(oc_n), .port_power_request_i(req),
        .port_power_enable_n_o(pen_n), .port_power_enable_n_oe_o(pen_oe),
        .port_overcurrent_o(oc_flag), .port_dp_i(dp), .port_dm_i(dm),
        .port_slow_slew_o(slew), .up_rx_i(up_rx), .up_rx_bit_o(up_bit),
        .bit_clk_o(bit_clk), .suspend_req_i(susp), .suspend_indicator_o(susp_o),
        .power_cfg_o(cfg), .ident_o(ident), .enum_enable_o(enum_en));

    hub_mem_model mem (
        .rst_i(sys_rst_i | ~mode), .scl_i(clk_w), .sda_i(dat_w), .content_i(content),
        .sda_o(m_d), .sda_oe_o(m_oe), .cmd_o(cmd));

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // wait n edges, then let the registered outputs settle before looking
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    function automatic logic [3:0] exp_power(input logic [3:0] r, input logic [3:0] oc,
                                             input logic gang);
        if (gang) begin
            return (|r && !(|oc)) ? 4'hf : 4'h0;
        end
        return r & ~oc;
    endfunction

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // reset, configuration and port power runs
    // ----------------------------------------------------------------
    task automatic run(input logic m, input logic p, input logic g);
        int n;
        logic drove, gang;
        logic [3:0] r, oc, ls;
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        mode <= m;
        strap_pwr <= p;
        strap_gang <= g;
        content <= 48'({$urandom, $urandom});
        tick(5);
        check("enum_in_reset", enum_en, 1'b0);
        check("power_in_reset", pen_oe, 4'h0);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        n = 0;
        drove = 1'b0;
        while (enum_en !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
            drove = drove | (clk_oe === 1'b1);
        end
        check("enum_enable", enum_en, 1'b1);
        check("clk_pin_driven", drove, m);
        check("pins_released", {clk_oe, dat_oe}, 2'b00);
        if (m) begin
            check("read_before_enum", n > 56 * 2 * SCLH, 1'b1);
            check("read_command", cmd, 9'h180);
            check("ident_mem", ident, content[47:16]);
            check("cfg_mem", cfg, {content[0], content[1]});
            gang = content[1];
        end else begin
            check("ident_default", ident, 32'h12345678);
            check("cfg_strap", cfg, {p, g});
            // a late strap change has to be ignored until the next reset
            @(posedge sys_clk_i);
            strap_pwr <= ~p;
            tick(8);
            check("cfg_static", cfg, {p, g});
            gang = g;
        end
        for (int i = 0; i < 4; i++) begin
            // first pass is a fixed corner: all ports requested, overcurrent on port 0
            r = (i == 0) ? 4'hf : 4'($urandom);
            oc = 4'h1 << ((i == 0) ? 0 : ($urandom % 4));
            @(posedge sys_clk_i);
            req <= r;
            tick(3);
            check("power_on", pen_oe, exp_power(r, 4'h0, gang));
            @(posedge sys_clk_i);
            oc_n <= ~oc;
            tick(6);
            check("power_oc", pen_oe, exp_power(r, oc, gang));
            check("drive_low", pen_n, 4'h0);
            if (!gang) begin
                check("oc_flag", oc_flag, oc);
            end
            @(posedge sys_clk_i);
            oc_n <= 4'hf;
            req <= 4'h0;
            tick(6);
            check("oc_flag_clear", oc_flag, 4'h0);
        end
        ls = 4'($urandom);
        @(posedge sys_clk_i);
        dm <= ls;
        dp <= ~ls;
        up_rx <= $urandom % 2;
        susp <= $urandom % 2;
        tick(1);
        check("suspend", susp_o, susp);
        tick(8);
        check("slew", slew, ls);
        check("up_rx_bit", up_bit, up_rx);
        n = 0;
        drove = bit_clk;
        repeat (8) begin
            tick(1);
            n += (bit_clk !== drove);
            drove = bit_clk;
        end
        check("bit_clk_toggles", n, 8 * 2 / 4);
    endtask

    initial begin
        void'($urandom(19349));
        for (int k = 0; k < 4; k++) begin
            run(k[1], 1'($urandom), k[0]);
        end
        final_report();
    end
endmodule

`default_nettype wire
